// File: verilog/uart_mode_config_regs.sv
// Mode registers one and two, pointer, tail register map and receive-side control of one UART channel.
`default_nettype none
module uart_mode_config_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [9:0] bus_addr,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic bus_byte,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_ack,
  input wire logic ptr_reset_cmd,
  input wire logic err_reset_cmd,
  input wire logic modem_mode,
  input wire logic [7:0] input_pins,
  input wire logic top_valid,
  input wire logic top_advance,
  input wire logic top_break,
  input wire logic top_framing,
  input wire logic top_parity,
  input wire logic start_bit,
  input wire logic fifo_full,
  input wire logic fifo_pop,
  input wire logic receiver_ready_flag,
  output logic rts_out,
  output logic rx_irq,
  output logic break_received_flag,
  output logic framing_error_flag,
  output logic parity_error_flag,
  output logic [7:0] output_pins,
  output logic [7:0] line_mode_one_out,
  output logic [7:0] line_mode_two_out,
  output logic [7:0] baud_divider_low_out,
  output logic parity_enable,
  output logic parity_force,
  output logic parity_odd_or_high,
  output logic multidrop_address,
  output logic flow_disabled
);
  typedef struct packed {
    logic ptr_two_r;
    logic [7:0] mode_one_r;
    logic [7:0] mode_two_r;
    logic [7:0] divider_r;
    logic [7:0] vector_r;
    logic [7:0] out_pins_r;
    logic [7:0] rdata_r;
    logic ack_r;
    logic rts_r;
    logic blk_break_r;
    logic blk_frame_r;
    logic blk_parity_r;
  } regs_state_type;

  regs_state_type st_r;
  regs_state_type st_nxt;
  logic [7:0] pins_sync;
  logic bus_go;
  logic rd_go;
  logic wr_go;
  logic rx_flow_on;

  ////////////////////////////////////////////////////////////////////////////////
  uart_pin_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(input_pins),
    .sync_out(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Any master, internal or external, is served; only byte transfers are taken.
  assign bus_go = bus_sel && bus_byte;
  assign rd_go = bus_go && !bus_write;
  assign wr_go = bus_go && bus_write;

  // Transmitter flow bit of mode register two is bit 5; the receiver's flow bit is bit 7 of mode register one.
  assign flow_disabled = st_r.mode_one_r[uart_mode_pkg::BIT_RX_FLOW]
    && st_r.mode_two_r[uart_mode_pkg::BIT_ERR_MODE];
  assign rx_flow_on = st_r.mode_one_r[uart_mode_pkg::BIT_RX_FLOW]
    && !flow_disabled && !modem_mode;

  function automatic logic in_test_range(input logic [9:0] a);
    in_test_range = (a >= uart_mode_pkg::OFS_TEST_FIRST)
      && (a <= uart_mode_pkg::OFS_TEST_LAST);
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack_r = bus_go;
    st_nxt.rdata_r = uart_mode_pkg::READ_IDLE;
    if (ptr_reset_cmd)
      st_nxt.ptr_two_r = 1'b0;
    if (bus_go && bus_addr == uart_mode_pkg::OFS_LINE_MODE)
    begin
      if (!st_r.ptr_two_r)
      begin
        if (bus_write)
          st_nxt.mode_one_r = bus_wdata;
        else
          st_nxt.rdata_r = st_r.mode_one_r;
        st_nxt.ptr_two_r = 1'b1;
      end
      else
      begin
        if (bus_write)
          st_nxt.mode_two_r = bus_wdata;
        else
          st_nxt.rdata_r = st_r.mode_two_r;
      end
    end
    if (wr_go && bus_addr == uart_mode_pkg::OFS_DIVIDER_LOW)
      st_nxt.divider_r = bus_wdata;
    if (rd_go && bus_addr == uart_mode_pkg::OFS_DIVIDER_LOW)
      st_nxt.rdata_r = st_r.divider_r;
    if (wr_go && bus_addr == uart_mode_pkg::OFS_VECTOR)
      st_nxt.vector_r = bus_wdata;
    if (rd_go && bus_addr == uart_mode_pkg::OFS_VECTOR)
      st_nxt.rdata_r = st_r.vector_r;
    if (rd_go && bus_addr == uart_mode_pkg::OFS_INPUT_PINS)
      st_nxt.rdata_r = pins_sync;
    // Test locations read as zero and ignore writes here.
    if (bus_go && in_test_range(bus_addr))
      st_nxt.rdata_r = uart_mode_pkg::READ_IDLE;
    if (wr_go && bus_addr == uart_mode_pkg::OFS_OUT_SET)
      st_nxt.out_pins_r = st_r.out_pins_r | bus_wdata;
    if (wr_go && bus_addr == uart_mode_pkg::OFS_OUT_CLEAR)
      st_nxt.out_pins_r = st_r.out_pins_r & ~bus_wdata;
    // Receiver flow: negate on start bit into a full FIFO, reassert once a slot frees.
    if (rx_flow_on)
    begin
      if (start_bit && fifo_full)
        st_nxt.rts_r = 1'b0;
      else if (!st_r.rts_r && (!fifo_full || fifo_pop))
        st_nxt.rts_r = 1'b1;
    end
    // Block error accumulation; a new top character wins over the reset command.
    if (err_reset_cmd)
    begin
      st_nxt.blk_break_r = 1'b0;
      st_nxt.blk_frame_r = 1'b0;
      st_nxt.blk_parity_r = 1'b0;
    end
    if (top_valid && top_advance && !modem_mode)
    begin
      st_nxt.blk_break_r = st_nxt.blk_break_r | top_break;
      st_nxt.blk_frame_r = st_nxt.blk_frame_r | top_framing;
      st_nxt.blk_parity_r = st_nxt.blk_parity_r | top_parity;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r.ptr_two_r <= 1'b0;
      st_r.mode_one_r <= uart_mode_pkg::RST_LINE_MODE_ONE;
      st_r.mode_two_r <= uart_mode_pkg::RST_LINE_MODE_TWO;
      st_r.divider_r <= uart_mode_pkg::RST_DIVIDER_LOW;
      st_r.vector_r <= uart_mode_pkg::RST_VECTOR;
      st_r.out_pins_r <= uart_mode_pkg::RST_OUT_PINS;
      st_r.rdata_r <= uart_mode_pkg::READ_IDLE;
      st_r.ack_r <= 1'b0;
      st_r.rts_r <= 1'b1;
      st_r.blk_break_r <= 1'b0;
      st_r.blk_frame_r <= 1'b0;
      st_r.blk_parity_r <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic err_block;
  logic [1:0] pm;
  assign err_block = st_r.mode_one_r[uart_mode_pkg::BIT_ERR_MODE] && !modem_mode;
  assign pm = st_r.mode_one_r[uart_mode_pkg::BIT_PM_HI:uart_mode_pkg::BIT_PM_LO];

  assign bus_rdata = st_r.rdata_r;
  assign bus_ack = st_r.ack_r;
  assign rts_out = st_r.rts_r;
  assign rx_irq = st_r.mode_one_r[uart_mode_pkg::BIT_IRQ_SEL]
    ? fifo_full : receiver_ready_flag;
  assign break_received_flag = err_block ? st_r.blk_break_r : (top_valid && top_break);
  assign framing_error_flag = err_block ? st_r.blk_frame_r : (top_valid && top_framing);
  assign parity_error_flag = err_block ? st_r.blk_parity_r : (top_valid && top_parity);
  assign output_pins = st_r.out_pins_r;
  assign line_mode_one_out = st_r.mode_one_r;
  assign line_mode_two_out = st_r.mode_two_r;
  assign baud_divider_low_out = st_r.divider_r;
  assign parity_enable = (pm != uart_mode_pkg::PM_NONE);
  assign parity_force = (pm == uart_mode_pkg::PM_FORCE);
  assign parity_odd_or_high = st_r.mode_one_r[uart_mode_pkg::BIT_PT]
    && (pm == uart_mode_pkg::PM_WITH || pm == uart_mode_pkg::PM_FORCE);
  assign multidrop_address = (pm == uart_mode_pkg::PM_MULTIDROP)
    && st_r.mode_one_r[uart_mode_pkg::BIT_PT];

  ////////////////////////////////////////////////////////////////////////////////
  chk_pointer_advance: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_sel && bus_byte && bus_addr == uart_mode_pkg::OFS_LINE_MODE && !ptr_reset_cmd
      |=> st_r.ptr_two_r)
    else $error("Mode pointer did not move to register two.");
  chk_pointer_hold_two: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r.ptr_two_r && !ptr_reset_cmd |=> st_r.ptr_two_r)
    else $error("Mode pointer left register two without a reset.");
  chk_out_set: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_go && bus_addr == uart_mode_pkg::OFS_OUT_SET
      |=> (output_pins & $past(bus_wdata)) == $past(bus_wdata))
    else $error("Output set command left bits clear.");
  chk_out_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_go && bus_addr == uart_mode_pkg::OFS_OUT_CLEAR |=> (output_pins & $past(bus_wdata)) == 8'h00)
    else $error("Output clear command left bits set.");
  chk_flow_both_off: assert property (@(posedge core_clk) disable iff (!resetn)
    flow_disabled && st_r.rts_r |=> st_r.rts_r)
    else $error("Flow request moved while flow control was disabled.");
  chk_flow_negate: assert property (@(posedge core_clk) disable iff (!resetn)
    rx_flow_on && start_bit && fifo_full |=> !rts_out)
    else $error("Flow request not negated on start bit into full FIFO.");
  chk_flow_modem: assert property (@(posedge core_clk) disable iff (!resetn)
    modem_mode |=> $stable(rts_out))
    else $error("Flow request changed in modem mode.");
  chk_irq_select: assert property (@(posedge core_clk) disable iff (!resetn)
    rx_irq == (st_r.mode_one_r[uart_mode_pkg::BIT_IRQ_SEL] ? fifo_full : receiver_ready_flag))
    else $error("Receive interrupt source mismatched.");
  chk_block_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    err_block && break_received_flag && !err_reset_cmd |=> break_received_flag)
    else $error("Block mode break status lost without reset.");
  chk_parity_none: assert property (@(posedge core_clk) disable iff (!resetn)
    pm == uart_mode_pkg::PM_NONE |-> !parity_enable && !parity_force)
    else $error("Parity active in no-parity mode.");

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers, pointer moves and status behaviour checked cycle by cycle.
  chk_byte_only: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_sel && !bus_byte
      |=> !bus_ack)
    else $error("Access without byte qualifier was acknowledged.");
  chk_ack_taken: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_sel && bus_byte
      |=> bus_ack)
    else $error("Byte access was not acknowledged.");
  chk_idle_rdata: assert property (@(posedge core_clk) disable iff (!resetn)
    !bus_go
      |=> bus_rdata == uart_mode_pkg::READ_IDLE)
    else $error("Read data not idle outside an answer.");
  chk_out_read_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_go && (bus_addr == uart_mode_pkg::OFS_OUT_SET || bus_addr == uart_mode_pkg::OFS_OUT_CLEAR)
      |=> bus_rdata == uart_mode_pkg::READ_IDLE)
    else $error("Output command offset returned data on read.");
  chk_pointer_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    ptr_reset_cmd && !(bus_go && bus_addr == uart_mode_pkg::OFS_LINE_MODE)
      |=> !st_r.ptr_two_r)
    else $error("Pointer reset did not return to register one.");
  chk_mode_one_write: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_go && bus_addr == uart_mode_pkg::OFS_LINE_MODE && !st_r.ptr_two_r
      |=> line_mode_one_out == $past(bus_wdata))
    else $error("Write at pointer one did not reach mode register one.");
  chk_mode_one_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_go && bus_addr == uart_mode_pkg::OFS_LINE_MODE && st_r.ptr_two_r
      |=> $stable(line_mode_one_out))
    else $error("Access at pointer two changed mode register one.");
  chk_flow_reassert: assert property (@(posedge core_clk) disable iff (!resetn)
    rx_flow_on && !rts_out && !fifo_full
      |=> rts_out)
    else $error("Flow request not restored with a free FIFO slot.");
  chk_flow_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    !rx_flow_on
      |=> $stable(rts_out))
    else $error("Flow request moved with receiver flow control off.");
  chk_char_status: assert property (@(posedge core_clk) disable iff (!resetn)
    !err_block
      |-> parity_error_flag == (top_valid && top_parity))
    else $error("Character mode parity status differs from top character.");
  chk_err_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    err_reset_cmd && !top_advance
      |=> !st_r.blk_break_r && !st_r.blk_frame_r && !st_r.blk_parity_r)
    else $error("Error status reset left block status set.");
  chk_parity_force: assert property (@(posedge core_clk) disable iff (!resetn)
    pm == uart_mode_pkg::PM_FORCE
      |-> parity_enable && parity_force)
    else $error("Forced parity mode not decoded.");
  chk_multidrop_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    pm != uart_mode_pkg::PM_MULTIDROP
      |-> !multidrop_address)
    else $error("Address character flagged outside multidrop mode.");
endmodule // uart_mode_config_regs
`default_nettype wire

// File: verilog/uart_mode_pkg.sv
// Package with register offsets, field positions and reset values of the mode block.
`default_nettype none
package uart_mode_pkg;
  localparam logic [9:0] OFS_LINE_MODE = 10'h1C0;
  localparam logic [9:0] OFS_DIVIDER_LOW = 10'h1DC;
  localparam logic [9:0] OFS_TEST_FIRST = 10'h1E0;
  localparam logic [9:0] OFS_TEST_LAST = 10'h1EC;
  localparam logic [9:0] OFS_VECTOR = 10'h1F0;
  localparam logic [9:0] OFS_INPUT_PINS = 10'h1F4;
  localparam logic [9:0] OFS_OUT_SET = 10'h1F8;
  localparam logic [9:0] OFS_OUT_CLEAR = 10'h1FC;
  localparam int BIT_RX_FLOW = 7;
  localparam int BIT_IRQ_SEL = 6;
  localparam int BIT_ERR_MODE = 5;
  localparam int BIT_PM_HI = 4;
  localparam int BIT_PM_LO = 3;
  localparam int BIT_PT = 2;
  localparam logic [7:0] RST_LINE_MODE_ONE = 8'h00;
  localparam logic [7:0] RST_LINE_MODE_TWO = 8'h00;
  localparam logic [7:0] RST_DIVIDER_LOW = 8'h00;
  localparam logic [7:0] RST_VECTOR = 8'h0F;
  localparam logic [7:0] RST_OUT_PINS = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [1:0] PM_WITH = 2'h0;
  localparam logic [1:0] PM_FORCE = 2'h1;
  localparam logic [1:0] PM_NONE = 2'h2;
  localparam logic [1:0] PM_MULTIDROP = 2'h3;
endpackage
`default_nettype wire

// File: verilog/uart_pin_sync.sv
// Two-flop synchroniser for the input port pins.
`default_nettype none
module uart_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first_r;
    logic [WIDTH-1:0] second_r;
  } sync_state_type;
  sync_state_type st_r;
  sync_state_type st_nxt;
  always_comb
  begin
    st_nxt.first_r = async_in;
    st_nxt.second_r = st_r.first_r;
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign sync_out = st_r.second_r;
endmodule // uart_pin_sync
`default_nettype wire

// File: tb/rx_line_model.sv
// Line-side model: a small receive FIFO fed by start bits and drained on request.
`default_nettype none
module rx_line_model #(
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic pop,
  output logic start_bit,
  output logic fifo_pop,
  output logic fifo_full,
  output logic receiver_ready_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  int count;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= 0;
      start_bit <= 1'b0;
      fifo_pop <= 1'b0;
    end
    else
    begin
      // A start bit still arrives while full, the overrun case.
      start_bit <= push;
      fifo_pop <= pop && count > 0;
      if (push && count < DEPTH)
        count <= count + 1;
      else if (pop && count > 0)
        count <= count - 1;
    end
  end
  assign fifo_full = (count == DEPTH);
  assign receiver_ready_flag = (count != 0);
endmodule // rx_line_model
`default_nettype wire

// File: tb/tb_uart_mode_config_regs.sv
// Self-checking bench for the mode register block.
`default_nettype none
module tb_uart_mode_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, resetn = 1'b0, bus_sel = 1'b0, bus_write = 1'b0, bus_byte = 1'b1;
  logic [9:0] bus_addr = 10'h000;
  logic [7:0] bus_wdata = 8'h00, input_pins = 8'h00, rd, bus_rdata, output_pins;
  logic [7:0] line_mode_one_out, line_mode_two_out, baud_divider_low_out;
  logic ptr_reset_cmd = 1'b0, err_reset_cmd = 1'b0, modem_mode = 1'b0, top_valid = 1'b0;
  logic top_advance = 1'b0, top_break = 1'b0, top_framing = 1'b0, top_parity = 1'b0;
  logic push = 1'b0, pop = 1'b0, bus_ack, start_bit, fifo_full, fifo_pop, receiver_ready_flag;
  logic rts_out, rx_irq, break_received_flag, framing_error_flag, parity_error_flag;
  logic parity_enable, parity_force, parity_odd_or_high, multidrop_address, flow_disabled;
  int miscompares = 0, n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  uart_mode_config_regs DUT (.core_clk, .resetn, .bus_addr, .bus_sel, .bus_write, .bus_byte,
    .bus_wdata, .bus_rdata, .bus_ack, .ptr_reset_cmd, .err_reset_cmd, .modem_mode,
    .input_pins, .top_valid, .top_advance, .top_break, .top_framing, .top_parity,
    .start_bit, .fifo_full, .fifo_pop, .receiver_ready_flag, .rts_out, .rx_irq,
    .break_received_flag, .framing_error_flag, .parity_error_flag, .output_pins,
    .line_mode_one_out, .line_mode_two_out, .baud_divider_low_out, .parity_enable,
    .parity_force, .parity_odd_or_high, .multidrop_address, .flow_disabled);
  rx_line_model line (.core_clk, .resetn, .push, .pop, .start_bit, .fifo_pop, .fifo_full,
    .receiver_ready_flag);
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One byte access; the answer is taken while the acknowledge stands.
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    int i;
    bus_write = w;
    bus_addr = a;
    bus_wdata = d;
    bus_sel = 1'b1;
    tick(1);
    bus_sel = 1'b0;
    for (i = 0; i < 4 && bus_ack !== 1'b1; i++) tick(1);
    if (bus_ack !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    rd = bus_rdata;
    tick(1);
  endtask
  // A request without the byte qualifier must go unanswered.
  task automatic nak(input logic [9:0] a, input logic [7:0] d);
    bus_byte = 1'b0;
    bus_write = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    bus_sel = 1'b1;
    tick(1);
    bus_sel = 1'b0;
    bus_byte = 1'b1;
    cmp(8'h00, {7'h00, bus_ack});
    tick(1);
  endtask
  // Mode changes are made only while the line model is quiet.
  task automatic wm1(input logic [7:0] v);
    ptr_reset_cmd = 1'b1;
    tick(1);
    ptr_reset_cmd = 1'b0;
    acc(1'b1, uart_mode_pkg::OFS_LINE_MODE, v);
  endtask
  task automatic pc(input int n);
    repeat (n)
    begin
      push = 1'b1;
      tick(1);
      push = 1'b0;
      tick(1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int k;
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    acc(1'b0, uart_mode_pkg::OFS_LINE_MODE, 8'h00);
    cmp(uart_mode_pkg::RST_LINE_MODE_ONE, rd);
    // Mode two keeps its transmitter flow bit clear so receiver flow stays usable.
    acc(1'b1, uart_mode_pkg::OFS_LINE_MODE, 8'h14);
    cmp(8'h00, line_mode_one_out);
    cmp(8'h14, line_mode_two_out);
    acc(1'b0, uart_mode_pkg::OFS_LINE_MODE, 8'h00);
    cmp(8'h14, rd);
    acc(1'b0, uart_mode_pkg::OFS_VECTOR, 8'h00);
    cmp(uart_mode_pkg::RST_VECTOR, rd);
    acc(1'b1, uart_mode_pkg::OFS_DIVIDER_LOW, 8'h5A);
    nak(uart_mode_pkg::OFS_DIVIDER_LOW, 8'hFF);
    acc(1'b0, uart_mode_pkg::OFS_DIVIDER_LOW, 8'h00);
    cmp(8'h5A, rd);
    cmp(8'h5A, baud_divider_low_out);
    // The unmapped probe stays clear of the factory-test range.
    acc(1'b0, 10'h100, 8'h77);
    cmp(8'h00, rd);
    cmp(uart_mode_pkg::RST_OUT_PINS, output_pins);
    acc(1'b1, uart_mode_pkg::OFS_OUT_SET, 8'hA5);
    acc(1'b1, uart_mode_pkg::OFS_OUT_CLEAR, 8'h05);
    cmp(8'hA0, output_pins);
    input_pins = 8'h3C;
    tick(3);
    acc(1'b0, uart_mode_pkg::OFS_INPUT_PINS, 8'h00);
    cmp(8'h3C, rd);
    for (k = 0; k < 8; k++)
    begin
      wm1({3'h0, k[2:0], 2'h0});
      cmp({4'h0, k[2:1] != 2'h2, k[2:1] == 2'h1, !k[2] && k[0],
        k[2:1] == 2'h3 && k[0]},
        {4'h0, parity_enable, parity_force, parity_odd_or_high, multidrop_address});
    end
    wm1(8'h00);
    pc(1);
    cmp(8'h01, {7'h00, rx_irq});
    wm1(8'h40);
    cmp(8'h00, {7'h00, rx_irq});
    pc(3);
    cmp(8'h01, {7'h00, rx_irq});
    wm1(8'hC0);
    pc(1);
    tick(2);
    cmp(8'h00, {7'h00, rts_out});
    pop = 1'b1;
    tick(1);
    pop = 1'b0;
    tick(2);
    cmp(8'h01, {7'h00, rts_out});
    modem_mode = 1'b1;
    pc(2);
    tick(2);
    cmp(8'h01, {7'h00, rts_out});
    modem_mode = 1'b0;
    pop = 1'b1;
    tick(1);
    pop = 1'b0;
    acc(1'b1, uart_mode_pkg::OFS_LINE_MODE, 8'h20);
    cmp(8'h01, {7'h00, flow_disabled});
    pc(2);
    tick(2);
    cmp(8'h01, {7'h00, rts_out});
    wm1(8'h00);
    top_valid = 1'b1;
    top_parity = 1'b1;
    tick(1);
    cmp(8'h01, {5'h00, break_received_flag, framing_error_flag, parity_error_flag});
    wm1(8'h20);
    top_break = 1'b1;
    top_framing = 1'b1;
    top_advance = 1'b1;
    tick(1);
    top_advance = 1'b0;
    top_break = 1'b0;
    top_framing = 1'b0;
    top_parity = 1'b0;
    tick(1);
    cmp(8'h07, {5'h00, break_received_flag, framing_error_flag, parity_error_flag});
    err_reset_cmd = 1'b1;
    tick(1);
    err_reset_cmd = 1'b0;
    tick(1);
    cmp(8'h00, {5'h00, break_received_flag, framing_error_flag, parity_error_flag});
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(1);
    cmp(8'h00, line_mode_one_out);
    stop_test();
  end
endmodule // tb_uart_mode_config_regs
`default_nettype wire
